// >>> src/ifer_pkg.sv
// Constants shared by the interrupt flag and enable register block
package ifer_pkg;
    // APB geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // Register byte offsets
    localparam logic [11:0] OFF_TRAP = 12'h000;
    localparam logic [11:0] OFF_VEC = 12'h004;
    localparam logic [11:0] OFF_FLG0 = 12'h008;
    localparam logic [11:0] OFF_FLG1 = 12'h00C;
    localparam logic [11:0] OFF_FLG4 = 12'h010;
    localparam logic [11:0] OFF_EN0 = 12'h014;
    localparam logic [11:0] OFF_EN1 = 12'h018;
    localparam logic [11:0] OFF_EN4 = 12'h01C;
    localparam logic [11:0] OFF_PRIO = 12'h040;
    localparam int PRIO_REGS = 12;
    // Source groups: index 0, 1, 2 stand for flag/enable registers zero, one, four
    localparam int GROUPS = 3;
    localparam int SLOTS = 48;
    localparam int PRIO_W = 3;
    // Implemented bit masks
    localparam logic [15:0] TRAP_MASK = 16'h0006;
    localparam logic [15:0] VEC_WR_MASK = 16'h8007;
    localparam logic [15:0] FLG0_MASK = 16'h3FEF;
    localparam logic [15:0] FLG1_MASK = 16'h20DB;
    localparam logic [15:0] FLG4_MASK = 16'h0002;
    // Field positions
    localparam int TRAP_STACK_BIT = 2;
    localparam int TRAP_OSC_BIT = 1;
    localparam int VEC_ALT_BIT = 15;
    localparam int VEC_DISABLE_BIT = 14;
    localparam int EXT0_BIT = 0;
    localparam int EXT1_BIT = 4;
    localparam int EXT2_BIT = 13;
    localparam int CONV_DONE_BIT = 13;
    // Reset values
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
endpackage

// >>> src/ifer_regs.sv
// Interrupt flag, enable, priority and control registers behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module ifer_regs
    import ifer_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ifer_pkg::ADDR_W-1:0] paddr,
    input wire logic [ifer_pkg::DATA_W-1:0] pwdata,
    output logic [ifer_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trap events and core status, same clock
    input wire logic stack_error_evt,
    input wire logic osc_failure_evt,
    input wire logic instr_disable_active,
    // Peripheral request pulses, same clock
    input wire logic [15:0] evt_flags_zero,
    input wire logic [15:0] evt_flags_one,
    input wire logic [15:0] evt_flags_four,
    // External interrupt pins, asynchronous
    input wire logic [2:0] ext_pin,
    // Towards the core
    output logic alternate_vector_select,
    output logic trap_pending,
    output logic [ifer_pkg::SLOTS-1:0] req_pending,
    output logic irq
);
    import ifer_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [15:0] trap_ff;
    logic [15:0] vec_ff;
    logic [GROUPS-1:0][15:0] flg_ff;
    logic [GROUPS-1:0][15:0] en_ff;
    logic [PRIO_W-1:0] prio_ff [SLOTS];
    logic [2:0] ext_s1_ff;
    logic [2:0] ext_s2_ff;
    logic [2:0] ext_d_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic pslverr_ff;
    logic [SLOTS-1:0] req_ff;
    logic irq_ff;
    logic trap_pend_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_en = access_ph & pwrite;
    wire [15:0] wdat = pwdata[15:0];
    wire hit_trap = (paddr == OFF_TRAP);
    wire hit_vec = (paddr == OFF_VEC);
    wire [GROUPS-1:0] hit_flg = {paddr == OFF_FLG4, paddr == OFF_FLG1, paddr == OFF_FLG0};
    wire [GROUPS-1:0] hit_en = {paddr == OFF_EN4, paddr == OFF_EN1, paddr == OFF_EN0};
    wire hit_prio = (paddr >= OFF_PRIO) && (paddr < OFF_PRIO + 12'(4 * PRIO_REGS))
        && (paddr[1:0] == 2'h0);
    wire [11:0] prio_off = paddr - OFF_PRIO;
    wire [3:0] prio_idx = prio_off[5:2];
    wire mapped = hit_trap | hit_vec | (|hit_flg) | (|hit_en) | hit_prio;
    wire [GROUPS-1:0][15:0] grp_mask = {FLG4_MASK, FLG1_MASK, FLG0_MASK};

    // Zero wait states: read data is captured in the setup cycle
    assign pready = access_ph;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff & access_ph;

    ////////////////////////////////////////////////////////////////////////
    // External pin synchroniser and edge selection
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ext_s1_ff <= 3'h0;
            ext_s2_ff <= 3'h0;
            ext_d_ff <= 3'h0;
        end else begin
            ext_s1_ff <= ext_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_d_ff <= ext_s2_ff;
        end
    end

    // Polarity 1 picks the falling edge, 0 the rising edge
    wire [2:0] ext_rise = ext_s2_ff & ~ext_d_ff;
    wire [2:0] ext_fall = ~ext_s2_ff & ext_d_ff;
    wire [2:0] ext_edge = (vec_ff[2:0] & ext_fall) | (~vec_ff[2:0] & ext_rise);

    // Events per group; external pins land in their documented slots
    logic [GROUPS-1:0][15:0] grp_evt;
    always_comb begin
        grp_evt[0] = evt_flags_zero;
        grp_evt[1] = evt_flags_one;
        grp_evt[2] = evt_flags_four;
        grp_evt[0][EXT0_BIT] = ext_edge[0];
        grp_evt[1][EXT1_BIT] = ext_edge[1];
        grp_evt[1][EXT2_BIT] = ext_edge[2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Trap status: hardware set wins over a software write
    // Built bit by bit: a shifted one-bit event would lose its value
    logic [15:0] trap_set;
    always_comb begin
        trap_set = 16'h0000;
        trap_set[TRAP_STACK_BIT] = stack_error_evt;
        trap_set[TRAP_OSC_BIT] = osc_failure_evt;
    end
    wire [15:0] nxt_trap = (((wr_en & hit_trap) ? wdat : trap_ff) | trap_set)
        & TRAP_MASK;

    // Control word: only vector select and polarity bits store
    wire [15:0] nxt_vec = (wr_en & hit_vec) ? (wdat & VEC_WR_MASK) : vec_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            trap_ff <= REG_RESET;
            vec_ff <= REG_RESET;
        end else begin
            trap_ff <= nxt_trap;
            vec_ff <= nxt_vec;
        end
    end

    assign alternate_vector_select = vec_ff[VEC_ALT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Flag and enable registers, one copy per group
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : gen_grp
            // Set from the source wins over a write of zero in the same cycle
            wire [15:0] nxt_flg = (((wr_en & hit_flg[g]) ? wdat : flg_ff[g]) | grp_evt[g])
                & grp_mask[g];
            wire [15:0] nxt_en = ((wr_en & hit_en[g]) ? wdat : en_ff[g])
                & grp_mask[g];
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    flg_ff[g] <= REG_RESET;
                    en_ff[g] <= REG_RESET;
                end else begin
                    flg_ff[g] <= nxt_flg;
                    en_ff[g] <= nxt_en;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Priority fields: four per word at bits 14:12, 10:8, 6:4, 2:0
    logic [15:0] prio_word [PRIO_REGS];
    wire [SLOTS-1:0] slot_impl = {grp_mask[2], grp_mask[1], grp_mask[0]};
    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : gen_slot
            wire prio_wr = wr_en & hit_prio & (prio_idx == 4'(s / 4));
            wire [PRIO_W-1:0] prio_in = wdat[(s % 4) * 4 +: PRIO_W];
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    prio_ff[s] <= PRIO_RESET;
                end else if (prio_wr && slot_impl[s]) begin
                    prio_ff[s] <= prio_in;
                end
            end
        end
        for (s = 0; s < PRIO_REGS; s++) begin : gen_pword
            always_comb begin
                prio_word[s] = 16'h0000;
                for (int j = 0; j < 4; j++) begin
                    if (slot_impl[s * 4 + j]) begin
                        prio_word[s][j * 4 +: PRIO_W] = prio_ff[s * 4 + j];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Request gating: flag, enable and a nonzero priority all needed
    logic [SLOTS-1:0] prio_on;
    always_comb begin
        for (int k = 0; k < SLOTS; k++) begin
            prio_on[k] = (prio_ff[k] != PRIO_OFF);
        end
    end
    wire [SLOTS-1:0] all_flg = {flg_ff[2], flg_ff[1], flg_ff[0]};
    wire [SLOTS-1:0] all_en = {en_ff[2], en_ff[1], en_ff[0]};
    wire [SLOTS-1:0] nxt_req = all_flg & all_en & prio_on;
    wire nxt_irq = |nxt_req;
    wire nxt_trap_pend = |trap_ff;

    // Registered so the core sees glitch-free levels
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            req_ff <= '0;
            irq_ff <= 1'b0;
            trap_pend_ff <= 1'b0;
        end else begin
            req_ff <= nxt_req;
            irq_ff <= nxt_irq;
            trap_pend_ff <= nxt_trap_pend;
        end
    end

    assign req_pending = req_ff;
    assign irq = irq_ff;
    assign trap_pending = trap_pend_ff;

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses read zero with an error
    logic [15:0] rd_sel;
    always_comb begin
        rd_sel = 16'h0000;
        if (hit_trap) begin
            rd_sel = trap_ff;
        end else if (hit_vec) begin
            rd_sel = vec_ff;
            rd_sel[VEC_DISABLE_BIT] = instr_disable_active;
        end else if (hit_prio) begin
            rd_sel = prio_word[prio_idx];
        end else begin
            for (int k = 0; k < GROUPS; k++) begin
                if (hit_flg[k]) begin
                    rd_sel = flg_ff[k];
                end
                if (hit_en[k]) begin
                    rd_sel = en_ff[k];
                end
            end
        end
    end
    wire [DATA_W-1:0] nxt_prdata = setup_ph ? {16'h0000, rd_sel} : prdata_ff;
    wire nxt_pslverr = setup_ph ? ~mapped : pslverr_ff;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // Trap flags
    a_stack_err_set: assert property (
        stack_error_evt |=> trap_ff[TRAP_STACK_BIT] ##1 trap_pending)
        else $error("stack error event did not set trap bit");
    a_osc_fail_set: assert property (
        osc_failure_evt |=> trap_ff[TRAP_OSC_BIT] && !trap_ff[0])
        else $error("oscillator failure event did not set trap bit");
    a_trap_write_back: assert property (
        wr_en && hit_trap && !stack_error_evt && !osc_failure_evt
        |=> trap_ff == ($past(pwdata[15:0]) & TRAP_MASK))
        else $error("trap write not stored");
    a_trap_quiet_hold: assert property (
        !trap_ff[TRAP_STACK_BIT] && !stack_error_evt && !(wr_en && hit_trap)
        |=> !trap_ff[TRAP_STACK_BIT])
        else $error("stack error bit set without an event");

    // Control word
    a_alt_vec_write: assert property (
        wr_en && hit_vec |=> alternate_vector_select == $past(pwdata[15]))
        else $error("vector select did not follow write");
    a_disable_readback: assert property (
        setup_ph && hit_vec |=> prdata[14] == $past(instr_disable_active))
        else $error("instruction disable status misread");
    a_ctrl_unimpl_zero: assert property (
        setup_ph && hit_vec |=> prdata[13:3] == 11'h000 ##0 pready)
        else $error("unimplemented control bits not zero");
    a_edge_sel_write: assert property (
        wr_en && hit_vec |=> vec_ff[2:0] == $past(pwdata[2:0]))
        else $error("edge polarity bits did not follow write");

    // External pins: only the chosen edge raises a flag
    a_ext0_fall_flag: assert property (
        vec_ff[0] && $fell(ext_s2_ff[0]) |=> flg_ff[0][EXT0_BIT])
        else $error("falling edge on pin 0 missed");
    a_ext2_rise_flag: assert property (
        !vec_ff[2] && $rose(ext_s2_ff[2]) |=> flg_ff[1][EXT2_BIT])
        else $error("rising edge on pin 2 missed");
    a_ext1_rise_flag: assert property (
        !vec_ff[1] && $rose(ext_s2_ff[1]) |=> flg_ff[1][EXT1_BIT])
        else $error("rising edge on pin 1 missed");
    a_ext0_wrong_edge: assert property (
        vec_ff[0] && $rose(ext_s2_ff[0]) && !flg_ff[0][EXT0_BIT] && !(wr_en && hit_flg[0])
        |=> !flg_ff[0][EXT0_BIT])
        else $error("rising edge on pin 0 flagged under falling polarity");

    // Source flags and their read-back
    a_conv_flag_set: assert property (
        evt_flags_zero[CONV_DONE_BIT] |=> flg_ff[0][CONV_DONE_BIT])
        else $error("converter done flag not set");
    a_conv_flag_sticky: assert property (
        flg_ff[0][CONV_DONE_BIT] && !(wr_en && hit_flg[0]) |=> flg_ff[0][CONV_DONE_BIT])
        else $error("converter done flag lost without a write");
    a_timer_two_set: assert property (
        evt_flags_zero[7] |=> flg_ff[0][7])
        else $error("timer two flag not set");
    a_timer_one_read: assert property (
        setup_ph && hit_flg[0] |=> prdata[3] == $past(flg_ff[0][3]))
        else $error("timer one flag misread");
    a_change_notify_set: assert property (
        evt_flags_one[3] |=> flg_ff[1][3])
        else $error("change notification flag not set");
    a_i2c_master_set: assert property (
        evt_flags_one[1] |=> flg_ff[1][1])
        else $error("bus master event flag not set");
    a_uart_err_set: assert property (
        evt_flags_four[1] |=> flg_ff[2][1])
        else $error("uart error flag not set");
    a_flag0_holes: assert property (
        setup_ph && hit_flg[0] |=> prdata[15:14] == 2'h0 && !prdata[4])
        else $error("flag register zero holes not zero");
    a_flag1_holes: assert property (
        setup_ph && hit_flg[1] |=> (prdata[15:0] & ~FLG1_MASK) == 16'h0000)
        else $error("flag register one holes not zero");
    a_flag4_only: assert property (
        setup_ph && hit_flg[2] |=> (prdata[15:0] & ~FLG4_MASK) == 16'h0000)
        else $error("flag register four holes not zero");

    // Software writes
    a_enable_mirror: assert property (
        wr_en && hit_en[0] |=> en_ff[0] == ($past(pwdata[15:0]) & FLG0_MASK))
        else $error("enable zero write not stored");
    a_flag_write_back: assert property (
        wr_en && hit_flg[0] && evt_flags_zero == 16'h0000 && ext_edge[0] == 1'b0
        |=> flg_ff[0] == ($past(pwdata[15:0]) & FLG0_MASK))
        else $error("flag zero write not stored");
    a_flag4_write_back: assert property (
        wr_en && hit_flg[2] && evt_flags_four == 16'h0000
        |=> flg_ff[2] == ($past(pwdata[15:0]) & FLG4_MASK))
        else $error("flag four write not stored");

    // Priority and request gating
    a_prio_off_blocks: assert property (
        prio_ff[3] == PRIO_OFF |=> !req_pending[3])
        else $error("priority zero source still requested");
    a_prio_field_read: assert property (
        setup_ph && hit_prio && prio_idx == 4'h0 |=> prdata[14:12] == $past(prio_ff[3]))
        else $error("priority field misread");
    a_req_needs_both: assert property (
        req_pending[3] |-> $past(flg_ff[0][3] && en_ff[0][3]))
        else $error("request without flag and enable");
    a_conv_req_level: assert property (
        req_pending[CONV_DONE_BIT]
        |-> $past(flg_ff[0][CONV_DONE_BIT] && en_ff[0][CONV_DONE_BIT]))
        else $error("converter request without flag and enable");
    a_irq_follows: assert property (
        flg_ff[1][0] && en_ff[1][0] && prio_ff[16] != PRIO_OFF |=> irq)
        else $error("interrupt not raised for pending source");
    a_irq_quiet: assert property (
        (all_flg & all_en) == '0 |=> !irq)
        else $error("interrupt raised with nothing pending");
endmodule
`default_nettype wire

// >>> testbench/ifer_src_model.sv
// Behavioural interrupt sources and core status lines facing the register block
`timescale 1ns/1ps
`default_nettype none
module ifer_src_model (
    // Clock
    input wire logic ref_clk,
    // Trap events and core status
    output logic stack_error_evt,
    output logic osc_failure_evt,
    output logic instr_disable_active,
    // Peripheral request pulses and pins
    output logic [15:0] evt_flags_zero,
    output logic [15:0] evt_flags_one,
    output logic [15:0] evt_flags_four,
    output logic [2:0] ext_pin
);
    // Quiet sources from time zero
    initial begin
        {stack_error_evt, osc_failure_evt, instr_disable_active} = 3'h0;
        {evt_flags_zero, evt_flags_one, evt_flags_four} = 48'h000000000000;
        ext_pin = 3'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One-cycle request pulse, launched and dropped just after an edge
    task automatic pulse(input logic [1:0] trap, input logic [15:0] f0, f1, f4);
        @(posedge ref_clk);
        {stack_error_evt, osc_failure_evt} <= trap;
        {evt_flags_zero, evt_flags_one, evt_flags_four} <= {f0, f1, f4};
        @(posedge ref_clk);
        {stack_error_evt, osc_failure_evt} <= 2'h0;
        {evt_flags_zero, evt_flags_one, evt_flags_four} <= 48'h000000000000;
    endtask
    // Pin levels and disable status move together at an edge
    task automatic set_lines(input logic [2:0] pins, input logic dis);
        @(posedge ref_clk);
        ext_pin <= pins;
        instr_disable_active <= dis;
    endtask
endmodule
`default_nettype wire

// >>> testbench/interrupt_flag_enable_regs_bench.sv
// Self-checking bench for the interrupt flag and enable register block
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_enable_regs_bench;
    import ifer_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, alternate_vector_select, trap_pending, irq;
    logic [SLOTS-1:0] req_pending;
    logic stack_error_evt, osc_failure_evt, instr_disable_active;
    logic [15:0] evt_flags_zero, evt_flags_one, evt_flags_four;
    logic [2:0] ext_pin;
    int num_errors = 0;
    int cmp_count = 0;
    // Registers in table order; masks are the implemented bits
    logic [11:0] offs [6] = '{OFF_TRAP, OFF_VEC, OFF_FLG0, OFF_FLG1, OFF_FLG4, OFF_EN0};
    logic [15:0] msks [6] = '{16'h0006, 16'h8007, 16'h3FEF, 16'h20DB, 16'h0002, 16'h3FEF};
    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    // Block and its sources
    ifer_regs u_ifer_regs (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stack_error_evt(stack_error_evt),
        .osc_failure_evt(osc_failure_evt), .instr_disable_active(instr_disable_active),
        .evt_flags_zero(evt_flags_zero), .evt_flags_one(evt_flags_one),
        .evt_flags_four(evt_flags_four), .ext_pin(ext_pin),
        .alternate_vector_select(alternate_vector_select), .trap_pending(trap_pending),
        .req_pending(req_pending), .irq(irq));
    ifer_src_model u_ifer_src_model (
        .ref_clk(ref_clk), .stack_error_evt(stack_error_evt),
        .osc_failure_evt(osc_failure_evt), .instr_disable_active(instr_disable_active),
        .evt_flags_zero(evt_flags_zero), .evt_flags_one(evt_flags_one),
        .evt_flags_four(evt_flags_four), .ext_pin(ext_pin));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and the single place the run ends
    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Value compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                num_errors++;
                print_verdict();
            end
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(r, exp);
    endtask
    // Let launched updates land before looking at registered outputs
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values, then all-ones and all-zeros through the six registers in the table
    task automatic t_regs();
        for (int i = 0; i < 6; i++) rdc(offs[i], 32'h00000000);
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], 32'hFFFFFFFF);
            rdc(offs[i], {16'h0000, msks[i]});
        end
        chk({31'h0, alternate_vector_select}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(offs[i], 32'h00000000);
            rdc(offs[i], 32'h00000000);
        end
        chk({31'h0, alternate_vector_select}, 32'h0);
    endtask
    // Every trap and peripheral source pulsed at once; only the three enabled ones request
    task automatic t_events();
        wr(OFF_EN0, 32'h00002000);
        wr(OFF_EN1, 32'h00000001);
        wr(OFF_EN4, 32'h00000002);
        u_ifer_src_model.pulse(2'h3, 16'hFFFF, 16'hFFFF, 16'hFFFF);
        settle();
        chk(req_pending[31:0], 32'h00012000);
        chk({16'h0000, req_pending[47:32]}, 32'h00000002);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, trap_pending}, 32'h1);
        rdc(OFF_TRAP, 32'h00000006);
        rdc(OFF_FLG0, 32'h00003FEE);
        rdc(OFF_FLG1, 32'h000000CB);
        rdc(OFF_FLG4, 32'h00000002);
        wr(OFF_EN0, 32'h00000000);
        wr(OFF_EN1, 32'h00000000);
        wr(OFF_EN4, 32'h00000000);
        settle();
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 6; i++) wr(offs[i], 32'h00000000);
        settle();
        chk({31'h0, trap_pending}, 32'h0);
    endtask
    // Zero priority silences a flagged, enabled source
    task automatic t_prio();
        wr(OFF_FLG0, 32'h00000008);
        wr(OFF_EN0, 32'h00000008);
        settle();
        chk(req_pending[31:0], 32'h00000008);
        rdc(OFF_PRIO, 32'h00004444);
        wr(OFF_PRIO, 32'h00000000);
        settle();
        chk(req_pending[31:0], 32'h00000000);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_EN0, 32'h00000000);
        wr(OFF_FLG0, 32'h00000000);
    endtask
    // Disable status is visible and cannot be written away
    task automatic t_disable();
        u_ifer_src_model.set_lines(3'h0, 1'b1);
        rdc(OFF_VEC, 32'h00004000);
        wr(OFF_VEC, 32'h00000000);
        rdc(OFF_VEC, 32'h00004000);
        u_ifer_src_model.set_lines(3'h0, 1'b0);
        rdc(OFF_VEC, 32'h00000000);
        wr(OFF_VEC, 32'h00007FF8);
        rdc(OFF_VEC, 32'h00000000);
    endtask
    // Each pin, each polarity: chosen edge sets its flag, opposite edge does not
    task automatic t_edges();
        logic [2:0] lvl;
        logic [31:0] e0, e1;
        for (int pol = 0; pol < 2; pol++) begin
            for (int p = 0; p < 3; p++) begin
                lvl = pol ? 3'h7 : 3'h0;
                e0 = (p == 0) ? 32'h00000001 : 32'h00000000;
                e1 = (p == 1) ? 32'h00000010 : (p == 2) ? 32'h00002000 : 32'h00000000;
                u_ifer_src_model.set_lines(lvl, 1'b0);
                wr(OFF_VEC, {29'h0, lvl});
                repeat (4) @(posedge ref_clk);
                wr(OFF_FLG0, 32'h00000000);
                wr(OFF_FLG1, 32'h00000000);
                u_ifer_src_model.set_lines(lvl ^ (3'h1 << p), 1'b0);
                repeat (3) @(posedge ref_clk);
                rdc(OFF_FLG0, e0);
                rdc(OFF_FLG1, e1);
                wr(OFF_FLG0, 32'h00000000);
                wr(OFF_FLG1, 32'h00000000);
                u_ifer_src_model.set_lines(lvl, 1'b0);
                repeat (3) @(posedge ref_clk);
                rdc(OFF_FLG0, 32'h00000000);
                rdc(OFF_FLG1, 32'h00000000);
            end
        end
    endtask
    // Unmapped word refuses with an error and reads zero
    task automatic t_unmapped();
        logic [31:0] r;
        logic e;
        apb(1'b1, 12'h020, 32'hFFFFFFFF, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h020, 32'h00000000, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h00000000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence after six cycles of reset
    initial begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        t_regs();
        t_events();
        t_prio();
        t_disable();
        t_edges();
        t_unmapped();
        print_verdict();
    end
endmodule
`default_nettype wire
